// file: spd_ctrl_model.sv
/*
 * spd_ctrl_model: behavioural display controller that clocks bits
 * into the driver, sets the shift direction and strobes the latches.
 * Assumes: ref_clk is the bench clock; the bench resolves the two
 * data pins from this model and the driver's output enables.
 */
`timescale 1ns/1ns
module spd_ctrl_model (
  // timing reference
  input  wire logic ref_clk,
  // link pins
  output logic      shift_clk,
  output logic      shift_way_select,
  output logic      data_a,
  output logic      data_b,
  output logic      latch_transparent_n
);
  // ****************************************
  // idle levels
  // ****************************************
  // every input known from time zero, shift clock parked low
  initial begin
    shift_clk           = 1'b0;
    shift_way_select    = 1'b1;
    data_a              = 1'b0;
    data_b              = 1'b0;
    latch_transparent_n = 1'b0;
  end

  // ****************************************
  // frame and strobe tasks
  // ****************************************
  // msb first; clock low ph core cycles, high ph+1; ph of 2 or more keeps every phase over 62 ns
  task automatic send(input logic [63:0] v, input int n, input logic fwd, input int ph);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk);
      shift_way_select <= fwd;
      data_a           <= fwd ? v[i] : ~data_a; // unused side keeps toggling
      data_b           <= fwd ? ~data_b : v[i];
      shift_clk        <= 1'b0;
      repeat (ph) @(posedge ref_clk);
      shift_clk        <= 1'b1;
      repeat (ph) @(posedge ref_clk);
    end
    // clock stands still between frames; released data no longer valid
    @(posedge ref_clk);
    shift_clk <= 1'b0;
    data_a    <= ~data_a;
    data_b    <= ~data_b;
  endtask

  // callers wait long after the last edge, far beyond 25 ns
  task automatic set_latch(input logic lvl);
    @(posedge ref_clk);
    latch_transparent_n <= lvl;
  endtask
endmodule

// file: spd_driver.sv
/*
 * spd_driver: 64-stage bidirectional shift chain, latch bank,
 * polarity and blanking, plus a small bit FIFO and a
 * Wishbone register slave.
 * Assumes: every pin input is asynchronous to ref_clk and the
 * shift clock stays at or below 8 MHz, so each phase is seen
 * by at least one core clock after synchronising.
 */
// What this block does
// - sixty-four chain stages, one latch each, each latch feeds one output
// - chain advances one stage per shift clock rising edge while the hold bit is clear
// - direction pin low shifts reverse, high shifts forward
// - forward: in at port a, N to N+1, out at port b; reverse mirrors
// - cascade port always shows the last chain stage
// - output one comes from chain stage one via latch and logic
// - shifting ignores latch, force and invert inputs
// - latch input high: latches follow the chain
// - latch input low: latches hold, outputs show stored data
// - force low: all outputs high if invert low, else low
// - force high: outputs are latch values, inverted when invert low
`timescale 1ns/1ns

// ****************************************
// bit FIFO
// ****************************************
module spd_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  // filling side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // draining side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  // pointers wrap by power of two only
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("spd_fifo depth must be a power of two >= 2");
  end
  if (WIDTH < 1) begin : g_chkw
    $error("spd_fifo width must be at least 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [LW-1:0]    cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != LW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign level     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next pointers, count and storage
  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = rd_q + AW'(1);
    end
    case ({push, pop})
      2'b10:   cnt_d = cnt_q + LW'(1);
      2'b01:   cnt_d = cnt_q - LW'(1);
      default: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end
endmodule

// ****************************************
// driver top
// ****************************************
module spd_driver
  import spd_pkg::*;
#(
  parameter int N = SPD_CHAIN_LEN
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // serial link pins
  input  wire logic                 shift_clk,
  input  wire logic                 shift_way_select,
  input  wire logic                 serial_port_a_i,
  output logic                      serial_port_a_o,
  output logic                      serial_port_a_oe,
  input  wire logic                 serial_port_b_i,
  output logic                      serial_port_b_o,
  output logic                      serial_port_b_oe,
  // control pins
  input  wire logic                 latch_transparent_n,
  input  wire logic                 output_force_n,
  input  wire logic                 invert_select_n,
  // parallel outputs
  output logic [N-1:0]              driver_outputs,
  // wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [SPD_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o
);
  localparam int LW = $clog2(SPD_FIFO_DEPTH+1);

  // register readback packs the bank in two words
  if (N != 64) begin : g_chk
    $error("spd_driver bank must be 64 channels");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  // order: clk, dir, a, b, le, force, inv
  logic [6:0] meta_q, sync_q;
  logic       sclk_prev_q;
  logic       sclk_q, dir_q, a_q, b_q;
  logic       le_q, force_q, inv_q;

  // two flops per pin; only sync_q is read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q      <= '0;
      sync_q      <= '0;
      sclk_prev_q <= 1'b0;
    end else begin
      meta_q      <= {shift_clk, shift_way_select,
                      serial_port_a_i, serial_port_b_i,
                      latch_transparent_n, output_force_n,
                      invert_select_n};
      sync_q      <= meta_q;
      sclk_prev_q <= sync_q[6];
    end
  end

  assign {sclk_q, dir_q, a_q, b_q, le_q, force_q, inv_q} = sync_q;

  // ****************************************
  // edge capture into the FIFO
  // ****************************************
  logic          sclk_rise;
  logic          ff_in_rdy, ff_out_vld, ff_pop;
  logic [1:0]    ff_out;
  logic [LW-1:0] ff_lvl;
  logic          in_bit;
  logic          hold_q, hold_d;

  // an edge is sampled no matter what the control pins do
  assign sclk_rise = sclk_q && !sclk_prev_q;
  // forward takes port a, reverse takes port b
  assign in_bit    = dir_q ? a_q : b_q;
  // drains one entry per cycle, faster than edges come, while hold_q is clear
  assign ff_pop    = ff_out_vld && !hold_q;

  spd_fifo #(
    .WIDTH (SPD_FIFO_WIDTH),
    .DEPTH (SPD_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_valid  (sclk_rise),
    .in_ready  (ff_in_rdy),
    .in_data   ({dir_q, in_bit}),
    .out_valid (ff_out_vld),
    .out_ready (!hold_q),
    .out_data  (ff_out),
    .level     (ff_lvl)
  );

  // ****************************************
  // shift chain
  // ****************************************
  logic [N-1:0] chain_q, chain_d, step;

  // per stage: forward takes stage below, reverse stage above
  for (genvar i = 0; i < N; i++) begin : g_stage
    if (i == 0) begin : g_lo
      assign step[i] = ff_out[1] ? ff_out[0] : chain_q[i+1];
    end else if (i == N-1) begin : g_hi
      assign step[i] = ff_out[1] ? chain_q[i-1] : ff_out[0];
    end else begin : g_mid
      assign step[i] = ff_out[1] ? chain_q[i-1] : chain_q[i+1];
    end
  end

  // one stage per popped edge
  always_comb begin
    chain_d = ff_pop ? step : chain_q;
  end

  // reset value is a convenience; contents stay undefined
  // until a full frame is shifted and latched
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chain_q <= SPD_DATA_RST;
    end else begin
      chain_q <= chain_d;
    end
  end

  // cascade: stage 64 out at b forward, stage 1 out at a reverse
  assign serial_port_b_o  = chain_q[N-1];
  assign serial_port_b_oe = dir_q;
  assign serial_port_a_o  = chain_q[0];
  assign serial_port_a_oe = !dir_q;

  // ****************************************
  // latch bank and output logic
  // ****************************************
  logic [N-1:0] latch_q, latch_d, drv_q, drv_d;

  always_comb begin
    latch_d = le_q ? chain_q : latch_q;
    if (!force_q) begin
      drv_d = {N{!inv_q}};
    end else begin
      drv_d = inv_q ? latch_q : ~latch_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= SPD_DATA_RST;
      drv_q   <= SPD_DATA_RST;
    end else begin
      latch_q <= latch_d;
      drv_q   <= drv_d;
    end
  end

  assign driver_outputs = drv_q;

  // ****************************************
  // wishbone registers
  // ****************************************
  logic        ack_q, ack_d, ovf_q, ovf_d;
  logic [31:0] rdat_q, rdat_d;
  logic        wr_stb, rd_stb;

  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_q; // write lands on the acked edge
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;

  // ack one cycle after request, dropped the cycle after
  always_comb begin
    ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
    hold_d = hold_q;
    ovf_d  = ovf_q;
    rdat_d = rdat_q;
    if (wr_stb && wb_sel_i[0]) begin
      if (wb_adr_i == SPD_OFS_CTRL) begin
        hold_d = wb_dat_i[SPD_CTRL_HOLD_BIT];
      end
      if (wb_adr_i == SPD_OFS_STAT && wb_dat_i[SPD_STAT_OVF_BIT]) begin
        ovf_d = 1'b0;
      end
    end
    // a lost edge sets the flag even while being cleared
    if (sclk_rise && !ff_in_rdy) begin
      ovf_d = 1'b1;
    end
    if (rd_stb) begin
      rdat_d = 32'h0;
      case (wb_adr_i)
        SPD_OFS_CTRL: rdat_d[SPD_CTRL_HOLD_BIT] = hold_q;
        SPD_OFS_STAT: begin
          rdat_d[SPD_STAT_DIR_BIT] = dir_q;
          rdat_d[SPD_STAT_OVF_BIT] = ovf_q;
          rdat_d[SPD_STAT_LE_BIT]  = le_q;
          rdat_d[SPD_STAT_LVL_LSB +: LW] = ff_lvl;
        end
        SPD_OFS_LATLO: rdat_d = latch_q[31:0];
        SPD_OFS_LATHI: rdat_d = latch_q[63:32];
        default:       rdat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q  <= 1'b0;
      hold_q <= SPD_HOLD_RST;
      ovf_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= ack_d;
      hold_q <= hold_d;
      ovf_q  <= ovf_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_fwd_pop;
    ff_pop && ff_out[1];
  endsequence
  sequence s_rev_pop;
    ff_pop && !ff_out[1];
  endsequence

  property p_fwd_shift;
    @(posedge ref_clk) disable iff (!rst_b)
    s_fwd_pop |=> chain_q[0] == $past(ff_out[0])
      && chain_q[N-1:1] == $past(chain_q[N-2:0]);
  endproperty
  a_fwd_shift: assert property (p_fwd_shift)
    else $error("forward shift wrong");

  property p_rev_shift;
    @(posedge ref_clk) disable iff (!rst_b)
    s_rev_pop |=> chain_q[N-1] == $past(ff_out[0])
      && chain_q[N-2:0] == $past(chain_q[N-1:1]);
  endproperty
  a_rev_shift: assert property (p_rev_shift)
    else $error("reverse shift wrong");

  property p_idle_stable;
    @(posedge ref_clk) disable iff (!rst_b)
    !ff_pop |=> $stable(chain_q);
  endproperty
  a_idle_stable: assert property (p_idle_stable)
    else $error("chain moved without an edge");

  property p_edge_queued;
    @(posedge ref_clk) disable iff (!rst_b)
    (sclk_rise && ff_in_rdy && !ff_pop) |=>
      ff_lvl == $past(ff_lvl) + LW'(1);
  endproperty
  a_edge_queued: assert property (p_edge_queued)
    else $error("shift edge not queued");

  property p_latch_follow;
    @(posedge ref_clk) disable iff (!rst_b)
    le_q |=> latch_q == $past(chain_q);
  endproperty
  a_latch_follow: assert property (p_latch_follow)
    else $error("latch not transparent");

  property p_latch_hold;
    @(posedge ref_clk) disable iff (!rst_b)
    !le_q |=> $stable(latch_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed while holding");

  property p_force;
    @(posedge ref_clk) disable iff (!rst_b)
    !force_q |=> driver_outputs == {N{!$past(inv_q)}};
  endproperty
  a_force: assert property (p_force)
    else $error("forced level wrong");

  property p_polarity;
    @(posedge ref_clk) disable iff (!rst_b)
    force_q |=> driver_outputs ==
      ($past(inv_q) ? $past(latch_q) : ~$past(latch_q));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("polarity wrong");

  property p_out_one;
    @(posedge ref_clk) disable iff (!rst_b)
    (force_q && inv_q && le_q) ##1 (force_q && inv_q)
      |=> driver_outputs[0] == $past(chain_q[0], 2);
  endproperty
  a_out_one: assert property (p_out_one)
    else $error("output one not from stage one");

  property p_cascade;
    @(posedge ref_clk) disable iff (!rst_b)
    dir_q |-> serial_port_b_oe && !serial_port_a_oe
      && serial_port_b_o == chain_q[N-1];
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascade port wrong");

  property p_bank_width;
    @(posedge ref_clk) disable iff (!rst_b)
    le_q ##1 force_q && inv_q |=>
      driver_outputs == $past(chain_q, 2);
  endproperty
  a_bank_width: assert property (p_bank_width)
    else $error("bank does not map one to one");

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property p_ack;
    @(posedge ref_clk) disable iff (!rst_b)
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack timing wrong");

endmodule

// file: spd_driver_tb.sv
/*
 * spd_driver_tb: self-checking bench for the 64-channel driver.
 * Assumes: the controller model drives the link pins; the bench
 * drives force, invert, reset and the Wishbone master.
 */
`timescale 1ns/1ns
module spd_driver_tb;
  import spd_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam logic [63:0] P1 = 64'hF0E1_D2C3_B4A5_9687;
  localparam logic [63:0] P2 = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] P3 = 64'hC35A_0FF0_1E2D_A55A;
  logic        ref_clk, rst_b, sclk, dir, m_a, m_b, le_n, force_n, inv_n;
  logic        a_o, a_oe, b_o, b_oe, pin_a, pin_b, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic [63:0] outs;
  int          n_errors, n_checks;

  // a data pin carries whichever party drives it
  assign pin_a = a_oe ? a_o : m_a;
  assign pin_b = b_oe ? b_o : m_b;

  // 20 MHz core clock
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  spd_ctrl_model m (.ref_clk(ref_clk), .shift_clk(sclk), .shift_way_select(dir), .data_a(m_a),
                    .data_b(m_b), .latch_transparent_n(le_n));

  spd_driver dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .shift_clk(sclk), .shift_way_select(dir),
    .serial_port_a_i(pin_a), .serial_port_a_o(a_o), .serial_port_a_oe(a_oe),
    .serial_port_b_i(pin_b), .serial_port_b_o(b_o), .serial_port_b_oe(b_oe),
    .latch_transparent_n(le_n), .output_force_n(force_n), .invert_select_n(inv_n),
    .driver_outputs(outs), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    t = 0;
    // ack and read data are taken at the same rising edge
    do begin
      @(posedge ref_clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (ack !== 1'b1) chk(64'h0, 64'h1, "bus ack missing");
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // latch pulse long enough to pass the pin synchronisers
  task automatic strobe();
    idle(10);
    m.set_latch(1'b1);
    idle(6);
    m.set_latch(1'b0);
    idle(8);
  endtask

  function automatic logic [63:0] rev(input logic [63:0] v);
    for (int i = 0; i < 64; i++) rev[i] = v[63 - i];
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  // outputs judged only after a whole frame is shifted and latched
  task automatic t_fwd();
    m.send(P1, 64, 1'b1, 3);
    strobe();
    chk(outs, P1, "forward frame");
    chk(64'(b_o), 64'(P1[63]), "cascade b");
    chk(64'({a_oe, b_oe}), 64'h1, "enables fwd");
    wb(1'b0, SPD_OFS_LATLO, 32'h0);
    chk(64'(rd), 64'(P1[31:0]), "latch low word");
    wb(1'b0, SPD_OFS_LATHI, 32'h0);
    chk(64'(rd), 64'(P1[63:32]), "latch high word");
  endtask

  // shift under force and invert, latches closed, then open them
  task automatic t_hold();
    @(posedge ref_clk);
    force_n <= 1'b0;
    inv_n   <= 1'b0;
    m.send(P2, 64, 1'b1, 3);
    @(posedge ref_clk);
    force_n <= 1'b1;
    inv_n   <= 1'b1;
    idle(10);
    chk(outs, P1, "held data");
    m.set_latch(1'b1);
    idle(8);
    chk(outs, P2, "shifted despite controls");
    m.send(64'h1, 1, 1'b1, 3);
    idle(10);
    chk(outs, {P2[62:0], 1'b1}, "one stage step");
    m.set_latch(1'b0);
    idle(4);
  endtask

  // all four force and invert combinations
  task automatic t_pol();
    logic [63:0] lat, exp;
    lat = {P2[62:0], 1'b1};
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      force_n <= k[1];
      inv_n   <= k[0];
      idle(6);
      exp = !k[1] ? {64{~k[0]}} : (k[0] ? lat : ~lat);
      chk(outs, exp, "force and invert");
    end
  endtask

  // reverse direction with a slow controller
  task automatic t_rev();
    m.send(P3, 64, 1'b0, 5);
    strobe();
    chk(outs, rev(P3), "reverse frame");
    chk(64'(a_o), 64'(P3[63]), "cascade a");
    chk(64'({a_oe, b_oe}), 64'h2, "enables rev");
  endtask

  // fill the bit queue while held until it refuses, then drain
  task automatic t_fifo();
    wb(1'b0, SPD_OFS_CTRL, 32'h0);
    chk(64'(rd[SPD_CTRL_HOLD_BIT]), 64'(SPD_HOLD_RST), "hold after reset");
    wb(1'b1, SPD_OFS_CTRL, 32'h1);
    m.send(P1, 10, 1'b1, 3);
    idle(6);
    wb(1'b0, SPD_OFS_STAT, 32'h0);
    chk(64'(rd[11:0]), 64'h803, "full, overflow, forward");
    wb(1'b1, SPD_OFS_CTRL, 32'h0);
    idle(30);
    wb(1'b1, SPD_OFS_STAT, 32'h2);
    wb(1'b0, SPD_OFS_STAT, 32'h0);
    chk(64'(rd[11:0]), 64'h001, "drained and cleared");
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk(64'(rd), 64'h0, "unmapped read");
    // a write without lane 0 must leave the hold bit alone
    sel <= 4'hE;
    wb(1'b1, SPD_OFS_CTRL, 32'h1);
    sel <= 4'hF;
    wb(1'b0, SPD_OFS_CTRL, 32'h0);
    chk(64'(rd), 64'h0, "lane 0 off ignored");
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // main sequence after a five-cycle reset
  initial begin
    rst_b   = 1'b0;
    force_n = 1'b1;
    inv_n   = 1'b1;
    cyc     = 1'b0;
    stb     = 1'b0;
    we      = 1'b0;
    adr     = 8'h00;
    sel     = 4'hF;
    wdat    = 32'h0;
    idle(5);
    rst_b <= 1'b1;
    idle(3);
    t_fifo();
    t_fwd();
    t_hold();
    t_pol();
    t_rev();
    conclude();
  end

  // whole run needs about 1900 cycles; a hang is cut well beyond that
  initial begin
    idle(20000);
    n_errors++;
    conclude();
  end
endmodule

// file: spd_pkg.sv
/*
 * spd_pkg: constants for the 64-channel serial to latched
 * parallel driver.
 * Assumes: a 20 MHz core clock; the bus is classic Wishbone
 * with 32-bit data and byte addresses.
 */
package spd_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int SPD_CHAIN_LEN  = 64;
  localparam int SPD_FIFO_DEPTH = 8;
  localparam int SPD_FIFO_WIDTH = 2;
  localparam int SPD_ADR_W      = 8;

  // ****************************************
  // timing
  // ****************************************
  localparam int SPD_CLK_PERIOD_NS = 50;
  localparam int SPD_SCLK_WIDTH_NS = 62;
  localparam int SPD_SCLK_WIDTH_CYC =
    (SPD_SCLK_WIDTH_NS + SPD_CLK_PERIOD_NS - 1)
    / SPD_CLK_PERIOD_NS;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] SPD_OFS_CTRL  = 8'h00;
  localparam logic [7:0] SPD_OFS_STAT  = 8'h04;
  localparam logic [7:0] SPD_OFS_LATLO = 8'h08;
  localparam logic [7:0] SPD_OFS_LATHI = 8'h0C;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int SPD_CTRL_HOLD_BIT = 0;
  localparam int SPD_STAT_DIR_BIT  = 0;
  localparam int SPD_STAT_OVF_BIT  = 1;
  localparam int SPD_STAT_LE_BIT   = 2;
  localparam int SPD_STAT_LVL_LSB  = 8;
  localparam logic SPD_HOLD_RST    = 1'b0;
  localparam logic [63:0] SPD_DATA_RST = 64'h0;

endpackage
